// *** core/rx_path_ais_pos_cfg.sv ***
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - With degrade enable set, insert line AIS while signal degrade is declared.
// - Path AIS forces cell delineation loss in ATM, flag fill (kill) in POS.
// - Trace mismatch, trace unstable, path AIS, pointer loss each assert path AIS.
// - Label mismatch/unstable, concat pointer loss, concat AIS also assert; enables reset one.
// - Fourteen alarms ORed onto alarm output only when enabled; enables reset zero.
// - FIFO clear bit empties FIFO and drops writes until written back to zero.
// - Descramble enable applies x^43+1 self-synchronous descrambling; resets to one.
// - Parity covers sixteen-bit data bus: even when bit set, odd otherwise.
// - FCS select: 00 none, 01 CRC-CCITT, 10 CRC-32, 11 reserved; reset 10.
// - FCS computed over whole packet after destuffing and descrambling.
// - Invert bit makes packet-available output active low.
// - FCS pass bit keeps FCS bytes in FIFO; otherwise they are stripped.
// - Frame kill input is driven by the path AIS result.
// - Kill type zero ends packet as abort; one ends it as FCS error.
// - Overrun raises interrupt only when its enable is set.
// - FCS error raises interrupt when enabled.
// - Aborted packet raises interrupt when enabled.
// - Too long or too short packets raise interrupts when enabled.
module rx_path_ais_pos_cfg
   import rx_pos_pkg::*;
#(
   parameter int FIFO_WORDS = 128
) (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   // Register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   // Defect indications
   input wire logic SIG_DEGRADE_I,
   input wire logic [7:0] PAIS_SRC_I,
   input wire logic [6:0] LINE_ALARM_I,
   input wire logic [6:0] PATH_ALARM_I,
   input wire logic ATM_MODE_I,
   // Consequent actions
   output logic LINE_AIS_INS_O,
   output logic PATH_AIS_O,
   output logic LCD_FORCE_O,
   output logic RECEIVE_ALARM_OUTPUT_O,
   // Destuffed frame bytes
   input wire logic [7:0] RX_BYTE_I,
   input wire logic RX_BYTE_VALID_I,
   input wire logic RX_FRAME_END_I,
   input wire logic RX_FRAME_ABORT_I,
   // FIFO read side
   input wire logic RX_READ_EN_I,
   output logic [15:0] RX_DATA_BUS_O,
   output logic RX_MOD_O,
   output logic RX_EOP_O,
   output logic RX_ERR_O,
   output logic RX_VALID_O,
   output logic RX_PARITY_OUTPUT_O,
   output logic PKT_AVAIL_OUTPUT_O,
   // Interrupt
   output logic IRQ_O
);
   localparam int AW = $clog2(FIFO_WORDS);

   // ---------------------------------------------------------------
   // Arithmetic helpers.
   // ---------------------------------------------------------------
   function automatic logic [50:0] descr(input logic [42:0] st, input logic [7:0] d);
      logic [42:0] t;
      logic [7:0] o;
      t = st;
      o = '0;
      for (int i = 0; i < 8; i++) begin
         o[i] = d[i] ^ t[DSC_TAPS-1];
         t = {t[41:0], d[i]};
      end
      return {t, o};
   endfunction

   function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d, input logic wide);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (wide) begin
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? CRC32_POLY : 32'h0000_0000);
         end else begin
            r = {16'h0000, (r[15:0] >> 1) ^ ((r[0] ^ d[i]) ? CRC16_POLY : 16'h0000)};
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // State.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic sd_ins_en;
      logic [7:0] pais_en;
      logic [6:0] alm_path;
      logic [6:0] alm_line;
      logic [7:0] cfg;
      logic [5:1] ien;
      logic [5:1] ist;
      logic [7:0] min_len;
      logic [15:0] max_len;
      logic [7:0] hwm;
      logic [7:0] rdata;
      logic lais;
      logic pais;
      logic lcd;
      logic alarm;
      logic pkt_avail_output;
      logic irq;
      wstate_t ws;
      logic [42:0] dsc;
      logic [31:0] crc;
      logic [15:0] len;
      logic [2:0] hc;
      logic [31:0] dly;
      logic hh;
      logic [7:0] hold;
      fifo_word_t pw;
      logic pv;
      logic perr;
      logic kd;
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [AW:0] neop;
      rd_out_t ro;
   } st_t;

   st_t s_r;
   st_t s_nxt;
   fifo_word_t mem [FIFO_WORDS];
   fifo_word_t wword;
   fifo_word_t rword;
   logic wreq;
   logic we;
   logic [5:1] ev;
   logic [5:1] clr_mask;
   logic [AW:0] used;
   logic clr;
   logic [2:0] fcs_n;
   logic [2:0] keep;
   logic [50:0] dres;
   logic [7:0] d;
   logic e_vld;
   logic [7:0] e_byte;
   logic [31:0] crc_new;
   logic [15:0] len_new;
   logic fcs_bad;
   logic rd_eop;
   fcs_sel_t fsel;

   assign rword = mem[s_r.rp[AW-1:0]];

   always_comb begin
      s_nxt = s_r;
      wreq = 1'b0;
      we = 1'b0;
      wword = '0;
      ev = '0;
      clr_mask = '0;
      e_vld = 1'b0;
      e_byte = '0;
      rd_eop = 1'b0;
      crc_new = s_r.crc;
      len_new = s_r.len;
      fcs_bad = 1'b0;
      clr = s_r.cfg[CFG_FIFO_CLR];
      used = s_r.wp - s_r.rp;
      fsel = fcs_sel_t'(s_r.cfg[CFG_FCS_SEL_LSB+:2]);
      fcs_n = (fsel == FCS_CRC32) ? 3'd4 : (fsel == FCS_CCITT) ? 3'd2 : 3'd0;
      keep = s_r.cfg[CFG_FCS_PASS] ? 3'd0 : fcs_n;
      dres = descr(s_r.dsc, RX_BYTE_I);
      d = s_r.cfg[CFG_DESCR] ? dres[7:0] : RX_BYTE_I;
      // -------------------------------------------------------------
      // Register port.
      // -------------------------------------------------------------
      if (REG_WR_I) begin
         unique case (REG_ADDR_I)
            OFS_LINE_AIS: s_nxt.sd_ins_en = REG_WDATA_I[LAIS_SD_BIT];
            OFS_PAIS_EN: s_nxt.pais_en = REG_WDATA_I;
            OFS_ALM_PATH: s_nxt.alm_path = REG_WDATA_I[6:0];
            OFS_ALM_LINE: s_nxt.alm_line = REG_WDATA_I[6:0];
            OFS_CFG: s_nxt.cfg = REG_WDATA_I;
            OFS_IRQ_EN: s_nxt.ien = REG_WDATA_I[5:1];
            OFS_MIN_LEN: s_nxt.min_len = REG_WDATA_I;
            OFS_MAX_LEN_LO: s_nxt.max_len[7:0] = REG_WDATA_I;
            OFS_MAX_LEN_HI: s_nxt.max_len[15:8] = REG_WDATA_I;
            OFS_HWM: s_nxt.hwm = REG_WDATA_I;
            OFS_IRQ_CLR: clr_mask = REG_WDATA_I[5:1];
            default: ;
         endcase
      end
      s_nxt.rdata = '0;
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            OFS_LINE_AIS: s_nxt.rdata = {s_r.sd_ins_en, 7'h00};
            OFS_PAIS_EN: s_nxt.rdata = s_r.pais_en;
            OFS_ALM_PATH: s_nxt.rdata = {1'b0, s_r.alm_path};
            OFS_ALM_LINE: s_nxt.rdata = {1'b0, s_r.alm_line};
            OFS_CFG: s_nxt.rdata = s_r.cfg;
            OFS_IRQ_EN: s_nxt.rdata = {2'b00, s_r.ien, 1'b0};
            OFS_IRQ_ST: s_nxt.rdata = {2'b00, s_r.ist, 1'b0};
            OFS_MIN_LEN: s_nxt.rdata = s_r.min_len;
            OFS_MAX_LEN_LO: s_nxt.rdata = s_r.max_len[7:0];
            OFS_MAX_LEN_HI: s_nxt.rdata = s_r.max_len[15:8];
            OFS_HWM: s_nxt.rdata = s_r.hwm;
            default: ;
         endcase
      end
      // -------------------------------------------------------------
      // Consequent actions and alarm output.
      // -------------------------------------------------------------
      s_nxt.lais = s_r.sd_ins_en & SIG_DEGRADE_I;
      s_nxt.pais = |(s_r.pais_en & PAIS_SRC_I);
      s_nxt.lcd = s_nxt.pais & ATM_MODE_I;
      s_nxt.alarm = |(LINE_ALARM_I & s_r.alm_line) | |(PATH_ALARM_I & s_r.alm_path);
      // -------------------------------------------------------------
      // Frame write side.
      // -------------------------------------------------------------
      if (RX_BYTE_VALID_I) begin
         s_nxt.dsc = dres[50:8];
      end
      unique case (s_r.ws)
         WS_IDLE, WS_RUN: begin
            if (s_r.pais) begin
               if (s_r.ws == WS_RUN) begin
                  ev[s_r.cfg[CFG_KILL_TYPE] ? IRQ_FCS : IRQ_ABRT] = 1'b1;
                  s_nxt.perr = 1'b1;
                  s_nxt.kd = !(RX_FRAME_ABORT_I || (RX_BYTE_VALID_I && RX_FRAME_END_I));
                  s_nxt.ws = WS_FLUSH;
               end else if (RX_BYTE_VALID_I && !RX_FRAME_END_I) begin
                  s_nxt.ws = WS_DROP;
               end
            end else if (RX_FRAME_ABORT_I) begin
               if (s_r.ws == WS_RUN) begin
                  ev[IRQ_ABRT] = 1'b1;
                  s_nxt.perr = 1'b1;
                  s_nxt.kd = 1'b0;
                  s_nxt.ws = WS_FLUSH;
               end
            end else if (RX_BYTE_VALID_I) begin
               if (s_r.ws == WS_IDLE) begin
                  s_nxt.crc = CRC_INIT;
                  s_nxt.len = '0;
                  s_nxt.hc = '0;
                  s_nxt.hh = 1'b0;
                  s_nxt.pv = 1'b0;
                  s_nxt.perr = 1'b0;
                  s_nxt.kd = 1'b0;
               end
               crc_new = crc_b(s_nxt.crc, d, fsel == FCS_CRC32);
               len_new = s_nxt.len + 16'd1;
               s_nxt.crc = crc_new;
               s_nxt.len = len_new;
               s_nxt.ws = WS_RUN;
               if (keep == 3'd0) begin
                  e_vld = 1'b1;
                  e_byte = d;
               end else if (s_nxt.hc < keep) begin
                  s_nxt.hc = s_nxt.hc + 3'd1;
               end else begin
                  e_vld = 1'b1;
                  e_byte = s_r.dly[8*(keep-3'd1)+:8];
               end
               s_nxt.dly = {s_r.dly[23:0], d};
               if (e_vld) begin
                  if (!s_nxt.hh) begin
                     wreq = s_nxt.pv;
                     wword = s_nxt.pw;
                     s_nxt.pv = 1'b0;
                     s_nxt.hold = e_byte;
                     s_nxt.hh = 1'b1;
                  end else begin
                     s_nxt.pw = '{data: {s_nxt.hold, e_byte}, mod: 1'b0, eop: 1'b0, err: 1'b0};
                     s_nxt.pv = 1'b1;
                     s_nxt.hh = 1'b0;
                  end
               end
               if (RX_FRAME_END_I) begin
                  if (fsel == FCS_CRC32) begin
                     fcs_bad = crc_new != CRC32_GOOD;
                  end else if (fsel == FCS_CCITT) begin
                     fcs_bad = crc_new[15:0] != CRC16_GOOD;
                  end
                  ev[IRQ_FCS] = fcs_bad;
                  ev[IRQ_MAXL] = 17'(len_new) > 17'(s_r.max_len) + 17'(fcs_n);
                  ev[IRQ_MINL] = 17'(len_new) < 17'(s_r.min_len) + 17'(fcs_n);
                  s_nxt.perr = fcs_bad | ev[IRQ_MAXL] | ev[IRQ_MINL];
                  s_nxt.ws = WS_FLUSH;
               end
            end
         end
         WS_FLUSH: begin
            wreq = 1'b1;
            if (s_r.hh) begin
               wword = '{data: {s_r.hold, 8'h00}, mod: 1'b1, eop: 1'b1, err: s_r.perr};
            end else if (s_r.pv) begin
               wword = '{data: s_r.pw.data, mod: 1'b0, eop: 1'b1, err: s_r.perr};
            end else begin
               wword = '{data: 16'h0000, mod: 1'b1, eop: 1'b1, err: s_r.perr};
            end
            s_nxt.hh = 1'b0;
            s_nxt.pv = 1'b0;
            s_nxt.ws = (s_r.kd && !RX_FRAME_ABORT_I && !(RX_BYTE_VALID_I && RX_FRAME_END_I)) ? WS_DROP : WS_IDLE;
         end
         WS_DROP: begin
            if (RX_FRAME_ABORT_I || (RX_BYTE_VALID_I && RX_FRAME_END_I)) begin
               s_nxt.ws = WS_IDLE;
            end
         end
      endcase
      if (wreq && !clr) begin
         if (used == (AW+1)'(FIFO_WORDS)) begin
            ev[IRQ_OVR] = 1'b1;
         end else begin
            we = 1'b1;
            s_nxt.wp = s_r.wp + 1'b1;
         end
      end
      // -------------------------------------------------------------
      // Read side.
      // -------------------------------------------------------------
      s_nxt.ro.val = 1'b0;
      if (RX_READ_EN_I && used != '0 && !clr) begin
         s_nxt.ro.w = rword;
         s_nxt.ro.val = 1'b1;
         s_nxt.ro.prty = s_r.cfg[CFG_PAR_EVEN] ? ^rword.data : ~^rword.data;
         s_nxt.rp = s_r.rp + 1'b1;
         rd_eop = rword.eop;
      end
      s_nxt.neop = s_r.neop + (AW+1)'(we && wword.eop) - (AW+1)'(rd_eop);
      if (clr) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.neop = '0;
      end
      s_nxt.pkt_avail_output = ((32'(used) * 2 > 32'(s_r.hwm)) || s_r.neop != '0) ^ s_r.cfg[CFG_RPA_INV];
      // -------------------------------------------------------------
      // Interrupt status.
      // -------------------------------------------------------------
      s_nxt.ist = (s_r.ist & ~clr_mask) | ev;
      s_nxt.irq = |(s_r.ist & s_r.ien);
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         s_r <= '0;
         s_r.pais_en <= RST_PAIS_EN;
         s_r.cfg <= RST_CFG;
         s_r.min_len <= RST_MIN_LEN;
         s_r.max_len <= RST_MAX_LEN;
         s_r.hwm <= RST_HWM;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (we) begin
         mem[s_r.wp[AW-1:0]] <= wword;
      end
   end

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   assign REG_RDATA_O = s_r.rdata;
   assign LINE_AIS_INS_O = s_r.lais;
   assign PATH_AIS_O = s_r.pais;
   assign LCD_FORCE_O = s_r.lcd;
   assign RECEIVE_ALARM_OUTPUT_O = s_r.alarm;
   assign RX_DATA_BUS_O = s_r.ro.w.data;
   assign RX_MOD_O = s_r.ro.w.mod;
   assign RX_EOP_O = s_r.ro.w.eop;
   assign RX_ERR_O = s_r.ro.w.err;
   assign RX_VALID_O = s_r.ro.val;
   assign RX_PARITY_OUTPUT_O = s_r.ro.prty;
   assign PKT_AVAIL_OUTPUT_O = s_r.pkt_avail_output;
   assign IRQ_O = s_r.irq;
endmodule // rx_path_ais_pos_cfg
`default_nettype wire

// *** shared/rx_pos_pkg.sv ***
`default_nettype none
package rx_pos_pkg;
   // ---------------------------------------------------------------
   // Register offsets.
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_LINE_AIS = 8'h94;
   localparam logic [7:0] OFS_PAIS_EN = 8'h95;
   localparam logic [7:0] OFS_ALM_PATH = 8'h96;
   localparam logic [7:0] OFS_ALM_LINE = 8'h97;
   localparam logic [7:0] OFS_CFG = 8'hA0;
   localparam logic [7:0] OFS_IRQ_EN = 8'hA1;
   localparam logic [7:0] OFS_IRQ_ST = 8'hA2;
   localparam logic [7:0] OFS_MIN_LEN = 8'hA3;
   localparam logic [7:0] OFS_MAX_LEN_LO = 8'hA4;
   localparam logic [7:0] OFS_MAX_LEN_HI = 8'hA5;
   localparam logic [7:0] OFS_HWM = 8'hA7;
   localparam logic [7:0] OFS_IRQ_CLR = 8'hB0;
   // ---------------------------------------------------------------
   // Reset values.
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_PAIS_EN = 8'hFF;
   localparam logic [7:0] RST_CFG = 8'h12;
   localparam logic [7:0] RST_MIN_LEN = 8'h04;
   localparam logic [15:0] RST_MAX_LEN = 16'h0600;
   localparam logic [7:0] RST_HWM = 8'h40;
   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int LAIS_SD_BIT = 7;
   localparam int CFG_KILL_TYPE = 7;
   localparam int CFG_FCS_PASS = 6;
   localparam int CFG_RPA_INV = 5;
   localparam int CFG_FCS_SEL_LSB = 3;
   localparam int CFG_PAR_EVEN = 2;
   localparam int CFG_DESCR = 1;
   localparam int CFG_FIFO_CLR = 0;
   localparam int IRQ_MINL = 5;
   localparam int IRQ_MAXL = 4;
   localparam int IRQ_ABRT = 3;
   localparam int IRQ_FCS = 2;
   localparam int IRQ_OVR = 1;
   // ---------------------------------------------------------------
   // Check sequence constants.
   // ---------------------------------------------------------------
   localparam logic [15:0] CRC16_POLY = 16'h8408;
   localparam logic [15:0] CRC16_GOOD = 16'hF0B8;
   localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
   localparam logic [31:0] CRC32_GOOD = 32'hDEBB_20E3;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam int DSC_TAPS = 43;
   typedef enum logic [1:0] {
      FCS_NONE = 2'b00,
      FCS_CCITT = 2'b01,
      FCS_CRC32 = 2'b10,
      FCS_RSVD = 2'b11
   } fcs_sel_t;
   typedef enum logic [1:0] {WS_IDLE, WS_RUN, WS_FLUSH, WS_DROP} wstate_t;
   typedef struct packed {
      logic [15:0] data;
      logic mod;
      logic eop;
      logic err;
   } fifo_word_t;
   typedef struct packed {
      fifo_word_t w;
      logic val;
      logic prty;
   } rd_out_t;
endpackage
`default_nettype wire

// *** tb/rx_link_reader.sv ***
`timescale 1ns/1ns
`default_nettype none
module rx_link_reader (
   // Clock, reset, stall
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic stall_i,
   // FIFO read side
   output logic rd_en_o,
   input wire logic [15:0] data_i,
   input wire logic mod_i,
   input wire logic eop_i,
   input wire logic err_i,
   input wire logic valid_i
);
   // ------------
   // Pops unless stalled, keeps each word.
   // ------------
   logic [18:0] got[$];
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_en_o <= 1'b0;
      end else begin
         rd_en_o <= !stall_i;
         if (valid_i === 1'b1) got.push_back({data_i, mod_i, eop_i, err_i});
      end
   end
endmodule // rx_link_reader
`default_nettype wire

// *** tb/rx_path_ais_pos_cfg_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rx_path_ais_pos_cfg_tb
   import rx_pos_pkg::*;
   ;
   logic CLK_SYS_I = 1'b0, ARST_N_I = 1'b0, REG_WR_I = 1'b0, REG_RD_I = 1'b0, SIG_DEGRADE_I = 1'b0;
   logic [7:0] REG_ADDR_I = 8'h00, REG_WDATA_I = 8'h00, PAIS_SRC_I = 8'h00, RX_BYTE_I = 8'h00;
   logic [6:0] LINE_ALARM_I = 7'h00, PATH_ALARM_I = 7'h00;
   logic ATM_MODE_I = 1'b0, RX_BYTE_VALID_I = 1'b0, RX_FRAME_END_I = 1'b0, RX_FRAME_ABORT_I = 1'b0;
   logic RX_READ_EN_I, stall = 1'b0, scr_on = 1'b1;
   logic [7:0] REG_RDATA_O;
   logic [15:0] RX_DATA_BUS_O;
   logic LINE_AIS_INS_O, PATH_AIS_O, LCD_FORCE_O, RECEIVE_ALARM_OUTPUT_O, RX_MOD_O, RX_EOP_O, RX_ERR_O;
   logic RX_VALID_O, RX_PARITY_OUTPUT_O, PKT_AVAIL_OUTPUT_O, IRQ_O;
   logic [42:0] hist = '0;
   logic [7:0] fq[$];
   int err_count = 0, n_tests = 0, cyc = 0;
   rx_path_ais_pos_cfg #(.FIFO_WORDS(8)) u_dut (.*);
   rx_link_reader u_rdr (.clk_i(CLK_SYS_I), .rst_n_i(ARST_N_I), .stall_i(stall), .rd_en_o(RX_READ_EN_I),
      .data_i(RX_DATA_BUS_O), .mod_i(RX_MOD_O), .eop_i(RX_EOP_O), .err_i(RX_ERR_O), .valid_i(RX_VALID_O));
   always #5 CLK_SYS_I = ~CLK_SYS_I;
   // ------------
   // Tasks.
   // ------------
   task automatic settle(input int n);
      repeat (n) @(posedge CLK_SYS_I);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK_SYS_I);
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      REG_WR_I <= 1'b1;
      @(posedge CLK_SYS_I);
      REG_WR_I <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      @(posedge CLK_SYS_I);
      REG_ADDR_I <= a;
      REG_RD_I <= 1'b1;
      @(posedge CLK_SYS_I);
      REG_RD_I <= 1'b0;
      #1 `CHK(REG_RDATA_O & m, e)
   endtask
   task automatic fill(input int n);
      fq.delete();
      for (int i = 0; i < n; i++) fq.push_back(8'h40 + 8'(i));
   endtask
   task automatic add_fcs(input logic [31:0] poly, input int nb, input logic bad);
      logic [31:0] c;
      c = (nb == 4) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      foreach (fq[i]) for (int b = 0; b < 8; b++) c = (c >> 1) ^ ((c[0] ^ fq[i][b]) ? poly : 32'h0);
      c = ~c ^ {31'h0, bad};
      for (int k = 0; k < nb; k++) fq.push_back(c[8*k +: 8]);
   endtask
   task automatic send(input int kill_at, input logic abort);
      logic [7:0] s;
      foreach (fq[i]) begin
         for (int b = 0; b < 8; b++) begin
            s[b] = scr_on ? fq[i][b] ^ hist[42] : fq[i][b];
            hist = {hist[41:0], s[b]};
         end
         @(posedge CLK_SYS_I);
         if (i == kill_at) PAIS_SRC_I <= 8'h01;
         RX_BYTE_I <= s;
         RX_BYTE_VALID_I <= 1'b1;
         RX_FRAME_END_I <= (i == fq.size() - 1) && !abort;
      end
      @(posedge CLK_SYS_I);
      RX_BYTE_VALID_I <= 1'b0;
      RX_FRAME_END_I <= 1'b0;
      RX_FRAME_ABORT_I <= abort;
      @(posedge CLK_SYS_I);
      RX_FRAME_ABORT_I <= 1'b0;
      PAIS_SRC_I <= 8'h00;
      settle(3);
   endtask
   task automatic drain;
      @(posedge CLK_SYS_I);
      stall <= 1'b0;
      settle(24);
   endtask
   task automatic expect_pkt(input int n, input logic err);
      logic [18:0] w;
      drain();
      for (int i = 0; i < n; i += 2) begin
         w = u_rdr.got.pop_front();
         `CHK(w[18:11], fq[i])
         if (i + 1 < n) `CHK(w[10:3], fq[i+1])
         `CHK(w[2:0], {i + 1 >= n, i + 2 >= n, i + 2 >= n && err})
      end
   endtask
   task automatic irq_case(input int bitn, input logic abort);
      logic [7:0] m = 8'h01 << bitn;
      @(posedge CLK_SYS_I);
      stall <= (bitn == IRQ_OVR);
      send(-1, abort);
      rchk(OFS_IRQ_ST, m, m);
      `CHK(IRQ_O, 1'b0)
      wr(OFS_IRQ_EN, m);
      settle(3);
      `CHK(IRQ_O, 1'b1)
      wr(OFS_IRQ_CLR, m);
      settle(3);
      `CHK(IRQ_O, 1'b0)
      wr(OFS_IRQ_EN, 8'h00);
      drain();
      u_rdr.got.delete();
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge CLK_SYS_I) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   // ------------
   // Tests.
   // ------------
   initial begin
      repeat (8) @(posedge CLK_SYS_I);
      ARST_N_I <= 1'b1;
      rchk(OFS_PAIS_EN, RST_PAIS_EN);
      rchk(OFS_ALM_PATH, 8'h00);
      rchk(OFS_ALM_LINE, 8'h00);
      rchk(OFS_CFG, RST_CFG);
      rchk(OFS_IRQ_EN, 8'h00);
      rchk(8'h50, 8'h00);
      $display("test regs done");
      for (int i = 0; i < 8; i++) begin
         @(posedge CLK_SYS_I);
         PAIS_SRC_I <= 8'h01 << i;
         ATM_MODE_I <= i[0];
         settle(2);
         `CHK({PATH_AIS_O, LCD_FORCE_O}, {1'b1, i[0]})
         wr(OFS_PAIS_EN, ~(8'h01 << i));
         settle(2);
         `CHK({PATH_AIS_O, LCD_FORCE_O}, 2'b00)
         wr(OFS_PAIS_EN, RST_PAIS_EN);
      end
      @(posedge CLK_SYS_I);
      PAIS_SRC_I <= 8'h00;
      ATM_MODE_I <= 1'b0;
      SIG_DEGRADE_I <= 1'b1;
      settle(2);
      `CHK(LINE_AIS_INS_O, 1'b0)
      wr(OFS_LINE_AIS, 8'h80);
      settle(2);
      `CHK(LINE_AIS_INS_O, 1'b1)
      @(posedge CLK_SYS_I);
      SIG_DEGRADE_I <= 1'b0;
      settle(2);
      `CHK(LINE_AIS_INS_O, 1'b0)
      $display("test AIS done");
      for (int j = 0; j < 14; j++) begin
         automatic logic [7:0] a = j < 7 ? OFS_ALM_PATH : OFS_ALM_LINE;
         @(posedge CLK_SYS_I);
         {LINE_ALARM_I, PATH_ALARM_I} <= 14'h0001 << j;
         wr(a, 8'h7F ^ (8'h01 << (j % 7)));
         settle(2);
         `CHK(RECEIVE_ALARM_OUTPUT_O, 1'b0)
         wr(a, 8'h01 << (j % 7));
         settle(2);
         `CHK(RECEIVE_ALARM_OUTPUT_O, 1'b1)
         wr(a, 8'h00);
      end
      $display("test alarms done");
      wr(OFS_CFG, 8'h13);
      fill(8);
      send(-1, 1'b0);
      `CHK({PKT_AVAIL_OUTPUT_O, u_rdr.got.size() == 0}, 2'b01)
      wr(OFS_CFG, 8'h02);
      @(posedge CLK_SYS_I);
      stall <= 1'b1;
      fill(5);
      send(-1, 1'b0);
      `CHK(PKT_AVAIL_OUTPUT_O, 1'b1)
      wr(OFS_CFG, 8'h22);
      settle(2);
      `CHK(PKT_AVAIL_OUTPUT_O, 1'b0)
      wr(OFS_CFG, 8'h06);
      expect_pkt(5, 1'b0);
      wr(OFS_IRQ_CLR, 8'hFF);
      for (int k = 0; k < 5; k++) begin
         wr(OFS_CFG, {1'b0, k[0], 1'b0, (k < 2) ? FCS_CCITT : FCS_CRC32, 1'b0, k != 1, 1'b0});
         scr_on = (k != 1);
         fill(4);
         add_fcs(k < 2 ? {16'h0000, CRC16_POLY} : CRC32_POLY, k < 2 ? 2 : 4, k == 4);
         send(-1, 1'b0);
         expect_pkt(k[0] ? fq.size() : 4, k == 4);
         rchk(OFS_IRQ_ST, k == 4 ? 8'h04 : 8'h00, 8'h04);
      end
      scr_on = 1'b1;
      $display("test frames done");
      wr(OFS_CFG, 8'h02);
      fill(2);
      irq_case(IRQ_MINL, 1'b0);
      wr(OFS_MAX_LEN_LO, 8'h05);
      wr(OFS_MAX_LEN_HI, 8'h00);
      fill(6);
      irq_case(IRQ_MAXL, 1'b0);
      wr(OFS_MAX_LEN_LO, 8'h00);
      wr(OFS_MAX_LEN_HI, 8'h06);
      fill(3);
      irq_case(IRQ_ABRT, 1'b1);
      fill(20);
      irq_case(IRQ_OVR, 1'b0);
      wr(OFS_CFG, 8'h12);
      fill(4);
      add_fcs(CRC32_POLY, 4, 1'b1);
      irq_case(IRQ_FCS, 1'b0);
      $display("test irq done");
      for (int t = 0; t < 2; t++) begin
         wr(OFS_CFG, {t[0], 7'h02});
         wr(OFS_IRQ_CLR, 8'hFF);
         fill(6);
         send(3, 1'b0);
         rchk(OFS_IRQ_ST, t ? 8'h04 : 8'h08, 8'h0C);
         drain();
         `CHK(u_rdr.got[$][1:0], 2'b11)
         u_rdr.got.delete();
      end
      $display("test kill done");
      complete_run();
   end
endmodule // rx_path_ais_pos_cfg_tb
`default_nettype wire

// *** tb/rx_pos_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module rx_pos_checker
   import rx_pos_pkg::*;
#(
   parameter int FIFO_WORDS = 128
) (
   // Clock, reset and register port
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_RDATA_O,
   // Defects and actions
   input wire logic SIG_DEGRADE_I,
   input wire logic [7:0] PAIS_SRC_I,
   input wire logic [6:0] LINE_ALARM_I,
   input wire logic [6:0] PATH_ALARM_I,
   input wire logic ATM_MODE_I,
   input wire logic LINE_AIS_INS_O,
   input wire logic PATH_AIS_O,
   input wire logic LCD_FORCE_O,
   input wire logic RECEIVE_ALARM_OUTPUT_O,
   // Read side and interrupt
   input wire logic RX_READ_EN_I,
   input wire logic [15:0] RX_DATA_BUS_O,
   input wire logic RX_VALID_O,
   input wire logic RX_PARITY_OUTPUT_O,
   input wire logic IRQ_O
);
   // ------------
   // Shadow enables.
   // ------------
   logic [7:0] lais_r, pais_r, apath_r, aline_r, cfg_r, irqen_r;
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         {lais_r, apath_r, aline_r, irqen_r} <= '0;
         pais_r <= RST_PAIS_EN;
         cfg_r <= RST_CFG;
      end else if (REG_WR_I) begin
         case (REG_ADDR_I)
            OFS_LINE_AIS: lais_r <= REG_WDATA_I;
            OFS_PAIS_EN: pais_r <= REG_WDATA_I;
            OFS_ALM_PATH: apath_r <= REG_WDATA_I;
            OFS_ALM_LINE: aline_r <= REG_WDATA_I;
            OFS_CFG: cfg_r <= REG_WDATA_I;
            OFS_IRQ_EN: irqen_r <= REG_WDATA_I;
            default: ;
         endcase
      end
   end
   // ------------
   // Assertions.
   // ------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);
   chk_line_ais_follow: assert property (LINE_AIS_INS_O == $past(SIG_DEGRADE_I && lais_r[LAIS_SD_BIT]))
      else $error("line AIS wrong");
   chk_path_ais_or: assert property (PATH_AIS_O == $past(|(PAIS_SRC_I & pais_r)))
      else $error("path AIS wrong");
   chk_lcd_force_atm: assert property (LCD_FORCE_O == (PATH_AIS_O && $past(ATM_MODE_I)))
      else $error("LCD force wrong");
   chk_alarm_or: assert property (RECEIVE_ALARM_OUTPUT_O ==
      $past(|({LINE_ALARM_I & aline_r[6:0], PATH_ALARM_I & apath_r[6:0]})))
      else $error("alarm wrong");
   chk_parity_sense: assert property (RX_VALID_O |->
      RX_PARITY_OUTPUT_O == ($past(cfg_r[CFG_PAR_EVEN]) ? ^RX_DATA_BUS_O : ~^RX_DATA_BUS_O))
      else $error("parity wrong");
   chk_clear_no_pop: assert property ($past(cfg_r[CFG_FIFO_CLR]) |-> !RX_VALID_O)
      else $error("pop in clear");
   chk_pop_after_req: assert property (RX_VALID_O |-> $past(RX_READ_EN_I))
      else $error("pop without request");
   chk_irq_masked: assert property ($past(irqen_r[5:1]) == 5'h00 |-> !IRQ_O)
      else $error("masked irq");
   chk_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
      else $error("stray read data");
   chk_pais_readback: assert property ($past(REG_RD_I && REG_ADDR_I == OFS_PAIS_EN) |->
      REG_RDATA_O == $past(pais_r))
      else $error("readback wrong");
endmodule // rx_pos_checker
bind rx_path_ais_pos_cfg rx_pos_checker #(.FIFO_WORDS(FIFO_WORDS)) u_chk (.*);
`default_nettype wire
